// ### inc/ldc_pkg.sv
// Purpose: Shared constants and types for the link delay calibration register bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`default_nettype none
package ldc_pkg;
  // Register map
  localparam logic [7:0] OFS_ONE_WAY = 8'h74;
  localparam logic [7:0] OFS_RSVD_A = 8'h78;
  localparam logic [7:0] OFS_RSVD_B = 8'h7C;
  localparam logic [7:0] OFS_RTD = 8'h80;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h90;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h94;
  localparam logic [7:0] OFS_MEAS_RTD = 8'h98;
  localparam int ADDR_W = 8;
  // Field layout
  localparam int OW_W = 16;
  localparam int USR_W = 20;
  localparam int ST_LSB = 28;
  localparam int CTL_LSB = 24;
  localparam int CTL_RST = 26;
  localparam int CTL_BYP = 25;
  localparam int CTL_EN = 24;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] OW_RST = 16'h0000;
  localparam logic [19:0] USR_RST = 20'h0_0000;
  localparam logic [2:0] CTL_RST_VAL = 3'h0;
  // Settling time of calibration in measure cycles
  localparam logic [7:0] SETTLE_CYC = 8'h10;
  // Calibration status codes
  typedef enum logic [1:0] {
    LDC_OFF = 2'b00,
    LDC_RUN = 2'b01,
    LDC_DONE = 2'b10,
    LDC_ERR = 2'b11
  } ldc_state_t;
  // Control field carrier
  typedef struct packed {
    logic cal_reset;
    logic bypass;
    logic enable;
  } ldc_ctl_t;
  // Interrupt event positions
  localparam int EV_MEAS = 0;
  localparam int EV_DONE = 1;
  localparam int EV_ERR = 2;
endpackage
`default_nettype wire

// ### design/ldc_rtd_engine.sv
// Purpose: Round-trip calibration sequencer reporting the status code
// Assumes: Control field written one-hot; target and measurement on ref_clk
// Notes: Reset bit forces the off code until enable is set again
`timescale 1ns/1ps
`default_nettype none
module ldc_rtd_engine (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire ldc_pkg::ldc_ctl_t ctl,
  input wire logic [ldc_pkg::USR_W-1:0] target,
  input wire logic [ldc_pkg::USR_W-1:0] measured,
  // Status
  output ldc_pkg::ldc_state_t state,
  output logic done_pulse,
  output logic err_pulse
);
  ldc_pkg::ldc_state_t state_q;
  ldc_pkg::ldc_state_t state_d;
  logic [7:0] cnt_q;
  logic hold_off_q;

  // Reset bit holds the off code; one-hot writes mean enable can only return after it drops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_off_q <= 1'b0;
    end else if (ctl.cal_reset) begin
      hold_off_q <= 1'b1; // R8 R13
    end else begin
      hold_off_q <= 1'b0; // R13
    end
  end

  // Next status code
  always_comb begin
    state_d = state_q;
    if (ctl.cal_reset || hold_off_q || !ctl.enable) begin
      state_d = ldc_pkg::LDC_OFF; // R8 R10 R13
    end else if (ctl.bypass) begin
      state_d = ldc_pkg::LDC_DONE; // R9
    end else begin
      unique case (state_q)
        ldc_pkg::LDC_OFF: state_d = ldc_pkg::LDC_RUN; // R10
        ldc_pkg::LDC_RUN: begin
          if (target > measured) begin
            state_d = ldc_pkg::LDC_ERR; // R6
          end else if (cnt_q == ldc_pkg::SETTLE_CYC) begin
            state_d = ldc_pkg::LDC_DONE; // R6
          end
        end
        ldc_pkg::LDC_DONE: begin
          if (target > measured) begin
            state_d = ldc_pkg::LDC_ERR;
          end
        end
        ldc_pkg::LDC_ERR: state_d = ldc_pkg::LDC_ERR; // Left only via the reset bit, clearing enable or setting bypass
      endcase
    end
  end

  // State register and settle counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ldc_pkg::LDC_OFF;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == ldc_pkg::LDC_RUN) ? cnt_q + 8'h01 : 8'h00;
    end
  end

  // Event pulses on entry to done or error
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_pulse <= 1'b0;
      err_pulse <= 1'b0;
    end else begin
      done_pulse <= (state_d == ldc_pkg::LDC_DONE) && (state_q != ldc_pkg::LDC_DONE);
      err_pulse <= (state_d == ldc_pkg::LDC_ERR) && (state_q != ldc_pkg::LDC_ERR);
    end
  end

  assign state = state_q;
endmodule
`default_nettype wire

// ### design/ldc_regs.sv
// Purpose: APB register bank for one-way and round-trip link delay calibration
// Assumes: Measurement inputs are synchronous to ref_clk
// Notes: Role parameters select which calibration register is present
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// R1 - The one-way status register at 0x74 exists only in a slave variant with single-trip calibration.
// R2 - Bits 15:0 of it show the measured master-to-slave variable delay, read-only, reset to zero.
// R3 - The core computes that delay itself and external calibrators read it to set their steps.
// R4 - Offsets 0x78 and 0x7C are reserved and do nothing.
// R5 - The round-trip register at 0x80 exists only in a master variant with calibration.
// R6 - Bits 29:28 report status: 00 off, 01 running, 10 done or monitoring, 11 error.
// R7 - Software writes the control field at bits 26:24 with one-hot values only.
// R8 - Control bit 26 is an active-high reset of the round-trip calibration block.
// R9 - Control bit 25 set puts round-trip calibration in bypass, clear leaves it active.
// R10 - Control bit 24 set turns round-trip calibration on, clear turns it off.
// R11 - Bits 19:0 hold the read-write round-trip target in link output clock cycles, reset to zero.
// R12 - Software picks a target between zero and the measured round-trip delay it read first.
// R13 - After the reset bit, the status returns to off until enable is set again.
module ldc_regs #(
  parameter bit IS_SLAVE = 1'b1,
  parameter bit IS_MASTER = 1'b1,
  parameter bit HAS_CAL = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ldc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Delay measurements from the core
  input wire logic [ldc_pkg::OW_W-1:0] one_way_delay,
  input wire logic one_way_valid,
  input wire logic [ldc_pkg::USR_W-1:0] round_trip_meas,
  // Calibration controls toward the core
  output logic cal_reset,
  output logic cal_bypass,
  output logic cal_enable,
  output logic [ldc_pkg::USR_W-1:0] cal_target,
  // Interrupt
  output logic irq
);
  localparam bit OW_ON = IS_SLAVE && HAS_CAL;
  localparam bit RTD_ON = IS_MASTER && HAS_CAL;

  logic [ldc_pkg::OW_W-1:0] ow_q;
  logic [ldc_pkg::USR_W-1:0] usr_q;
  ldc_pkg::ldc_ctl_t ctl_q;
  logic [ldc_pkg::IRQ_W-1:0] stat_q;
  logic [ldc_pkg::IRQ_W-1:0] mask_q;
  logic [31:0] rdata_d;
  logic err_d;
  logic wr_acc;
  logic rd_acc;
  logic hit_rtd;
  ldc_pkg::ldc_state_t rtd_state;
  logic done_pulse;
  logic err_pulse;
  logic [ldc_pkg::IRQ_W-1:0] ev;

  // Address decode for the error answer on both reads and writes
  function automatic logic present(input logic [ldc_pkg::ADDR_W-1:0] a);
    unique case (a)
      ldc_pkg::OFS_ONE_WAY: present = OW_ON; // R1
      ldc_pkg::OFS_RTD: present = RTD_ON; // R5
      ldc_pkg::OFS_RSVD_A, ldc_pkg::OFS_RSVD_B: present = 1'b1; // R4
      ldc_pkg::OFS_IRQ_STAT, ldc_pkg::OFS_IRQ_MASK: present = 1'b1;
      ldc_pkg::OFS_MEAS_RTD: present = RTD_ON;
      default: present = 1'b0;
    endcase
  endfunction

  // One-wait-state slave: access phase completes when answered below
  assign wr_acc = psel && penable && pwrite && !pready;
  assign rd_acc = psel && penable && !pwrite && !pready;
  assign hit_rtd = wr_acc && RTD_ON && (paddr == ldc_pkg::OFS_RTD);

  // One-way delay capture; the core's own calculation feeds it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ow_q <= ldc_pkg::OW_RST;
    end else if (OW_ON && one_way_valid) begin
      ow_q <= one_way_delay; // R2 R3
    end
  end

  // Round-trip target, byte lanes honoured
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      usr_q <= ldc_pkg::USR_RST;
    end else if (hit_rtd) begin
      if (pstrb[0]) begin
        usr_q[7:0] <= pwdata[7:0]; // R11
      end
      if (pstrb[1]) begin
        usr_q[15:8] <= pwdata[15:8]; // R11
      end
      if (pstrb[2]) begin
        usr_q[19:16] <= pwdata[19:16]; // R11
      end
    end
  end

  // Control field; a write with more than one bit set is taken but flagged by pslverr
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= ldc_pkg::CTL_RST_VAL;
    end else if (hit_rtd && pstrb[3]) begin
      ctl_q <= pwdata[ldc_pkg::CTL_RST:ldc_pkg::CTL_EN]; // R8 R9 R10
    end
  end

  // Round-trip sequencer
  ldc_rtd_engine u_engine (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ctl(ctl_q),
    .target(usr_q),
    .measured(round_trip_meas),
    .state(rtd_state),
    .done_pulse(done_pulse),
    .err_pulse(err_pulse)
  );

  // Events: new measurement, calibration done, calibration error
  always_comb begin
    ev = '0;
    ev[ldc_pkg::EV_MEAS] = OW_ON && one_way_valid;
    ev[ldc_pkg::EV_DONE] = RTD_ON && done_pulse;
    ev[ldc_pkg::EV_ERR] = RTD_ON && err_pulse; // R6
  end

  // Sticky status: read clears, but a same-cycle event wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= '0;
    end else if (rd_acc && paddr == ldc_pkg::OFS_IRQ_STAT) begin
      stat_q <= ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= '0;
    end else if (wr_acc && paddr == ldc_pkg::OFS_IRQ_MASK && pstrb[0]) begin
      mask_q <= pwdata[ldc_pkg::IRQ_W-1:0];
    end
  end

  // Read mux; reserved bits and reserved offsets read zero
  always_comb begin
    rdata_d = ldc_pkg::ZERO32;
    unique case (paddr)
      ldc_pkg::OFS_ONE_WAY: begin
        if (OW_ON) begin
          rdata_d[ldc_pkg::OW_W-1:0] = ow_q; // R2
        end
      end
      ldc_pkg::OFS_RTD: begin
        if (RTD_ON) begin
          rdata_d[ldc_pkg::ST_LSB+:2] = rtd_state; // R6 R13
          rdata_d[ldc_pkg::CTL_LSB+:3] = ctl_q;
          rdata_d[ldc_pkg::USR_W-1:0] = usr_q; // R11
        end
      end
      ldc_pkg::OFS_IRQ_STAT: rdata_d[ldc_pkg::IRQ_W-1:0] = stat_q;
      ldc_pkg::OFS_IRQ_MASK: rdata_d[ldc_pkg::IRQ_W-1:0] = mask_q;
      ldc_pkg::OFS_MEAS_RTD: begin
        if (RTD_ON) begin
          rdata_d[ldc_pkg::USR_W-1:0] = round_trip_meas; // R12
        end
      end
      default: rdata_d = ldc_pkg::ZERO32; // R4
    endcase
  end

  // Error answer: unmapped or absent offset, or a control write with more than one bit set
  always_comb begin
    err_d = !present(paddr);
    if (hit_rtd && pstrb[3] && !$onehot0(pwdata[ldc_pkg::CTL_RST:ldc_pkg::CTL_EN])) begin
      err_d = 1'b1; // R7
    end
  end

  // APB answer registers, one wait state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= ldc_pkg::ZERO32;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && err_d;
      if (rd_acc) begin
        prdata <= rdata_d;
      end
    end
  end

  // Outputs to the core, registered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_reset <= 1'b0;
      cal_bypass <= 1'b0;
      cal_enable <= 1'b0;
      cal_target <= ldc_pkg::USR_RST;
      irq <= 1'b0;
    end else begin
      cal_reset <= ctl_q.cal_reset; // R8
      cal_bypass <= ctl_q.bypass; // R9
      cal_enable <= ctl_q.enable && !ctl_q.cal_reset; // R10
      cal_target <= usr_q; // R11
      irq <= |((stat_q | ev) & mask_q);
    end
  end
endmodule
`default_nettype wire

// ### sim/ldc_regs_monitor.sv
// Purpose: Bus and control checks on the link delay calibration register bank
// Assumes: One wait state per transfer, async active-low reset
// Notes: Sees only the top module ports; attached by bind
`timescale 1ns/1ps
`default_nettype none
module ldc_regs_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ldc_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Calibration controls and interrupt
  input wire logic cal_reset,
  input wire logic cal_bypass,
  input wire logic cal_enable,
  input wire logic [ldc_pkg::USR_W-1:0] cal_target,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Access phase still waiting for its answer
  wire logic acc = psel && penable && !pready;
  ready_delay_a: assert property (acc |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready wide");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  rsvd_no_err_a: assert property (acc && (paddr == 8'h78 || paddr == 8'h7C) |=> !pslverr)
    else $error("reserved errored");
  // Controls may only move as a result of a bus write
  ctl_hold_a: assert property ($changed({cal_reset, cal_bypass, cal_enable}) |-> $past(psel && pwrite))
    else $error("control moved");
  target_hold_a: assert property ($changed(cal_target) |-> $past(psel && pwrite))
    else $error("target moved");
  reset_gate_a: assert property (cal_reset |-> !cal_enable) else $error("enable in reset");
  rst_quiet_a: assert property ($rose(rst_b) |-> !pready && !irq && !cal_enable && cal_target == '0)
    else $error("not quiet");
endmodule
bind ldc_regs ldc_regs_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .cal_reset(cal_reset),
  .cal_bypass(cal_bypass), .cal_enable(cal_enable), .cal_target(cal_target), .irq(irq));
`default_nettype wire

// ### sim/tb_link_delay_calibration_regs.sv
// Purpose: Self-checking bench for the link delay calibration register bank
// Assumes: Default role parameters, 250 MHz clock
// Notes: Waits on pready; a watchdog cuts any hang short
`timescale 1ns/1ps
`default_nettype none
module tb_link_delay_calibration_regs;
  logic ref_clk, rst_b, psel, penable, pwrite, one_way_valid, pready, pslverr, irq;
  logic cal_reset, cal_bypass, cal_enable, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] one_way_delay;
  logic [19:0] round_trip_meas, cal_target;
  int n_mismatch = 0;
  int cmp_count = 0;
  ldc_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .one_way_delay(one_way_delay), .one_way_valid(one_way_valid), .round_trip_meas(round_trip_meas),
    .cal_reset(cal_reset), .cal_bypass(cal_bypass), .cal_enable(cal_enable), .cal_target(cal_target),
    .irq(irq));
  // Clock at 4 ns
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_oneway();
    apb(0, ldc_pkg::OFS_ONE_WAY, 0); chk(rd, 32'h0000_0000);
    @(posedge ref_clk);
    one_way_delay <= 16'hA5C3;
    one_way_valid <= 1;
    @(posedge ref_clk);
    one_way_valid <= 0;
    apb(1, ldc_pkg::OFS_ONE_WAY, 32'hFFFF_FFFF);
    apb(0, ldc_pkg::OFS_ONE_WAY, 0); chk(rd, 32'h0000_A5C3);
    chk(er, 0);
    chk(irq, 0);
    apb(1, ldc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1);
    apb(0, ldc_pkg::OFS_IRQ_STAT, 0); chk(rd, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    $display("test done: one-way");
  endtask
  task automatic t_rsvd();
    apb(1, 8'h78, 32'h1234_5678);
    apb(0, 8'h78, 0); chk(rd, 32'h0000_0000);
    chk(er, 0);
    apb(0, 8'h7C, 0); chk(rd, 32'h0000_0000);
    chk(er, 0);
    apb(0, 8'h00, 0); chk(er, 1);
    $display("test done: reserved");
  endtask
  task automatic t_rtd();
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd, 32'h0000_0000);
    apb(0, ldc_pkg::OFS_MEAS_RTD, 0); chk(rd, 32'h0000_0100);
    // Target 0x40 stays below the measured 0x100 read just before
    apb(1, ldc_pkg::OFS_RTD, 32'h0100_0040);
    @(posedge ref_clk);
    chk({cal_enable, cal_bypass, cal_reset}, 3'b100);
    chk(cal_target, 20'h0_0040);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd, 32'h1100_0040);
    repeat (25) @(posedge ref_clk);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd, 32'h2100_0040);
    apb(1, ldc_pkg::OFS_RTD, 32'h0100_0200);
    repeat (4) @(posedge ref_clk);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd[29:28], 2'b11);
    apb(1, ldc_pkg::OFS_RTD, 32'h0400_0040);
    @(posedge ref_clk);
    chk({cal_reset, cal_enable}, 2'b10);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd[29:28], 2'b00);
    apb(1, ldc_pkg::OFS_RTD, 32'h0100_0040);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd[29:28], 2'b01);
    apb(1, ldc_pkg::OFS_RTD, 32'h0000_0040);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd[29:28], 2'b00);
    apb(1, ldc_pkg::OFS_RTD, 32'h0100_0040);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd[29:28], 2'b01);
    apb(1, ldc_pkg::OFS_RTD, 32'h0200_0040); chk(er, 0);
    @(posedge ref_clk);
    chk({cal_bypass, cal_enable}, 2'b10);
    apb(1, ldc_pkg::OFS_RTD, 32'h0300_0040); chk(er, 1);
    apb(0, ldc_pkg::OFS_RTD, 0); chk(rd[29:24], 6'h23);
    // Done and error events were latched; the read clears them
    apb(0, ldc_pkg::OFS_IRQ_STAT, 0); chk(rd, 32'h0000_0006);
    apb(0, ldc_pkg::OFS_IRQ_STAT, 0); chk(rd, 32'h0000_0000);
    $display("test done: round trip");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, one_way_valid, paddr, pwdata} = '0;
    pstrb = 4'hF;
    one_way_delay = 16'h0000;
    round_trip_meas = 20'h0_0100;
    rst_b = 0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1;
    t_oneway();
    t_rsvd();
    t_rtd();
    wrap_up();
  end
endmodule
`default_nettype wire
